/* File: hw/ebi_top.sv */
// external bus interface: sequencer, pin muxing, hold and ready handshakes
`include "ebi_defs.svh"
module ebi_top #(
  parameter int GPIO_W = 5
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 core_req_i,
  input  wire logic                 core_we_i,
  input  wire logic                 core_word_i,
  input  wire logic                 core_dp_mode_i,
  input  wire logic [23:0]          core_addr_i,
  input  wire logic [15:0]          core_wdata_i,
  input  wire logic [15:0]          direct_window_base_i,
  input  wire logic                 wait_bit_i,
  output logic                      core_ready_o,
  output logic                      core_ack_o,
  output logic [15:0]               core_rdata_o,
  output logic                      int_reg_sel_o,
  output logic                      int_ram_sel_o,
  output logic                      int_we_o,
  output logic [`EBI_INT_AW-1:0]    int_addr_o,
  output logic [15:0]               int_wdata_o,
  input  wire logic [15:0]          int_rdata_i,
  input  wire logic                 byte_mode_i,
  input  wire logic                 hold_n_i,
  input  wire logic                 ready_n_i,
  output logic [7:0]                addr_lo_o,
  output logic [7:0]                mid_o,
  output logic                      mid_oe_o,
  input  wire logic [7:0]           mid_i,
  output logic [7:0]                hi_o,
  output logic                      hi_oe_o,
  input  wire logic [7:0]           hi_i,
  output logic                      ctl_oe_o,
  output logic                      rw_o,
  output logic                      upper_lane_select_n_o,
  output logic                      ale_o,
  output logic                      strobe_n_o,
  output logic                      bus_grant_ack_n_o,
  output logic                      sysclk_o,
  input  wire logic                 gpio_dir_we_i,
  input  wire logic [GPIO_W-1:0]    gpio_dir_i,
  output logic [GPIO_W-1:0]         gpio_oe_o
);
  import ebi_pkg::*;

  generate
    if (GPIO_W < 1) begin : g_bad
      $error("GPIO_W must be at least 1");
    end
  endgenerate

  // =====================================================================
  // state and latched request
  ebi_state_t  state_r, state_nxt;
  logic [23:0] req_addr_r;
  logic        req_we_r, req_word_r, req_wait_r, byte_r, beat_r, beat_nxt;
  logic [15:0] req_wdata_r;
  logic        wait_done;

  ebi_dec_if dec_bus ();
  assign dec_bus.addr_in = core_addr_i;
  assign dec_bus.dp_mode = core_dp_mode_i;
  assign dec_bus.dp_base = direct_window_base_i;

  ebi_decode u_dec (
    .d (dec_bus.dec)
  );

  ebi_wait u_wait (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (state_r == ST_ADDR),
    .wait_en_i (req_wait_r),
    .ready_n_i (ready_n_i),
    .done_o    (wait_done)
  );

  // =====================================================================
  // beat and lane decode
  // bus width is caught per request so a change mid-transfer cannot split lanes
  wire        take      = (state_r == ST_IDLE) && core_req_i && hold_n_i;
  wire        two_beat  = req_word_r && (byte_r || req_addr_r[0]);
  wire        wide      = req_word_r && !two_beat;
  wire [23:0] cur_a     = req_addr_r + {23'h000000, beat_r};
  wire        odd       = cur_a[0];
  wire [7:0]  bdat      = (req_word_r && beat_r) ? req_wdata_r[15:8] : req_wdata_r[7:0];
  wire        hi_wr     = req_we_r && (byte_r || wide || !odd);
  wire        mid_wr    = req_we_r && !byte_r && (wide || odd);
  wire [7:0]  lane_in   = (!byte_r && odd) ? mid_i : hi_i;
  wire        last_beat = !two_beat || beat_r;
  wire        data_end  = (state_r == ST_DATA) && wait_done;

  // =====================================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    beat_nxt  = beat_r;
    case (state_r)
      ST_IDLE: begin
        beat_nxt = 1'b0;
        if (!hold_n_i) begin
          state_nxt = ST_HOLD;
        end else if (core_req_i) begin
          state_nxt = (dec_bus.tgt == TGT_EXT) ? ST_ADDR : ST_INT;
        end
      end
      ST_ADDR: state_nxt = ST_DATA;
      ST_DATA: begin
        if (wait_done) begin
          if (last_beat) begin
            state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_ADDR;
            beat_nxt  = 1'b1;
          end
        end
      end
      ST_INT:  state_nxt = ST_IDLE;
      ST_HOLD: state_nxt = hold_n_i ? ST_IDLE : ST_HOLD;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      beat_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      beat_r  <= beat_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_addr_r  <= '0;
      req_we_r    <= 1'b0;
      req_word_r  <= 1'b0;
      req_wait_r  <= 1'b0;
      byte_r      <= 1'b0;
      req_wdata_r <= '0;
    end else if (take) begin
      req_addr_r  <= dec_bus.eff_addr;
      req_we_r    <= core_we_i;
      req_word_r  <= core_word_i;
      req_wait_r  <= wait_bit_i;
      byte_r      <= byte_mode_i;
      req_wdata_r <= core_wdata_i;
    end
  end

  // =====================================================================
  // pin drive, all registered from the current phase
  wire in_addr = (state_r == ST_ADDR);
  wire in_data = (state_r == ST_DATA);
  wire on_bus  = in_addr || in_data;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_lo_o             <= '0;
      mid_o                 <= '0;
      mid_oe_o              <= 1'b0;
      hi_o                  <= '0;
      hi_oe_o               <= 1'b0;
      ctl_oe_o              <= 1'b1;
      rw_o                  <= 1'b1;
      upper_lane_select_n_o <= 1'b1;
      ale_o                 <= 1'b0;
      strobe_n_o            <= 1'b1;
      bus_grant_ack_n_o     <= 1'b1;
    end else begin
      addr_lo_o <= cur_a[7:0];
      // mid pins: address, then upper data in 16-bit mode only
      mid_o     <= (in_addr || byte_r) ? cur_a[15:8]
                   : (wide ? req_wdata_r[15:8] : bdat);
      mid_oe_o  <= in_addr || (in_data && (byte_r || mid_wr));
      // high pins: bank number, then low data lane
      hi_o      <= in_addr ? cur_a[23:16] : (wide ? req_wdata_r[7:0] : bdat);
      hi_oe_o   <= in_addr || (in_data && hi_wr);
      ctl_oe_o  <= (state_r != ST_HOLD);
      rw_o      <= !(on_bus && req_we_r);
      upper_lane_select_n_o <= !(on_bus && (odd || wide));
      ale_o     <= in_addr;
      strobe_n_o <= !in_data || wait_done;
      bus_grant_ack_n_o <= (state_r != ST_HOLD);
    end
  end

  // =====================================================================
  // core side answers and internal selects
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      core_ready_o  <= 1'b0;
      core_ack_o    <= 1'b0;
      core_rdata_o  <= '0;
      int_reg_sel_o <= 1'b0;
      int_ram_sel_o <= 1'b0;
    end else begin
      core_ready_o  <= (state_nxt == ST_IDLE);
      core_ack_o    <= (data_end && last_beat) || (state_r == ST_INT);
      int_reg_sel_o <= take && (dec_bus.tgt == TGT_REG);
      int_ram_sel_o <= take && (dec_bus.tgt == TGT_RAM);
      if (state_r == ST_INT) begin
        core_rdata_o <= int_rdata_i;
      end else if (data_end && !req_we_r) begin
        if (wide) begin
          core_rdata_o <= {mid_i, hi_i};
        end else if (req_word_r && beat_r) begin
          core_rdata_o[15:8] <= lane_in;
        end else begin
          core_rdata_o <= {8'h00, lane_in};
        end
      end
    end
  end

  assign int_we_o    = req_we_r;
  assign int_addr_o  = req_addr_r[`EBI_INT_AW-1:0];
  assign int_wdata_o = req_wdata_r;

  // =====================================================================
  // clock out and general pin directions
  // a toggle flop gives half rate; the core clock itself cannot leave a flop
  logic [GPIO_W-1:0] gpio_dir_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sysclk_o   <= 1'b0;
      gpio_dir_r <= {GPIO_W{`EBI_DIR_RST}};
    end else begin
      sysclk_o   <= !sysclk_o;
      if (gpio_dir_we_i) begin
        gpio_dir_r <= gpio_dir_i;
      end
    end
  end

  assign gpio_oe_o = gpio_dir_r;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_rw_write;
    (in_data && req_we_r) |=> !rw_o;
  endproperty
  a_rw_write: assert property (p_rw_write) else $error("direction high in write");

  property p_odd_lane;
    (on_bus && odd) |=> !upper_lane_select_n_o;
  endproperty
  a_odd_lane: assert property (p_odd_lane) else $error("upper lane not low");

  property p_ale_pulse;
    $rose(ale_o) |=> !ale_o && !strobe_n_o;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe shape");

  property p_strobe_excl;
    !strobe_n_o |-> !ale_o && ctl_oe_o;
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("strobe overlaps latch");

  property p_hold_release;
    (state_r == ST_HOLD) |=> !ctl_oe_o && !mid_oe_o && !hi_oe_o;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("bus not released");

  property p_grant;
    ((state_r == ST_IDLE) && !hold_n_i) |=> ##1 !bus_grant_ack_n_o;
  endproperty
  a_grant: assert property (p_grant) else $error("no grant acknowledge");

  property p_ready_stall;
    (in_data && !ready_n_i) |=> (state_r == ST_DATA) && $stable(cur_a);
  endproperty
  a_ready_stall: assert property (p_ready_stall) else $error("ready ignored");

  property p_wait_ins;
    (in_addr && req_wait_r) |=> in_data [*3];
  endproperty
  a_wait_ins: assert property (p_wait_ins) else $error("wait state missing");

  property p_byte_addr;
    (in_data && byte_r) |=> mid_oe_o && (mid_o == $past(cur_a[15:8]));
  endproperty
  a_byte_addr: assert property (p_byte_addr) else $error("mid pins left address");

  property p_reset;
    disable iff (1'b0) !rst_n_i |=> (state_r == ST_IDLE) && (gpio_oe_o == '0);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_int_route;
    (take && (dec_bus.tgt != TGT_EXT)) |=> (state_r == ST_INT) ##1 core_ack_o;
  endproperty
  a_int_route: assert property (p_int_route) else $error("internal access left");
endmodule

/* File: hw/ebi_defs.svh */
// constants for the external bus interface: decode ranges, wait timing, reset values
`ifndef EBI_DEFS_SVH
`define EBI_DEFS_SVH

// =====================================================================
// address map
`define EBI_BANK0      8'h00
`define EBI_REG_LAST   16'h007f
`define EBI_RAM_FIRST  16'h0080
`define EBI_RAM_LAST   16'h087f
`define EBI_INT_AW     12

// =====================================================================
// timing and reset values
`define EBI_WAIT_CYC   1
`define EBI_DIR_RST    1'b0

`endif

/* File: hw/ebi_pkg.sv */
// types shared by the external bus interface modules
package ebi_pkg;

  // =====================================================================
  // bus cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_INT  = 3'b011,
    ST_HOLD = 3'b100
  } ebi_state_t;

  // =====================================================================
  // decode targets
  typedef enum logic [1:0] {
    TGT_EXT = 2'b00,
    TGT_REG = 2'b01,
    TGT_RAM = 2'b10
  } ebi_tgt_t;

endpackage

/* File: hw/ebi_dec_if.sv */
// carrier between the sequencer and the address decoder
interface ebi_dec_if;
  import ebi_pkg::*;
  logic [23:0] addr_in;
  logic        dp_mode;
  logic [15:0] dp_base;
  logic [23:0] eff_addr;
  ebi_tgt_t    tgt;

  modport dec  (input addr_in, input dp_mode, input dp_base, output eff_addr, output tgt);
  modport user (output addr_in, output dp_mode, output dp_base, input eff_addr, input tgt);
endinterface

/* File: hw/ebi_decode.sv */
// effective address forming and internal/external decode
`include "ebi_defs.svh"
module ebi_decode (
  ebi_dec_if.dec d
);
  import ebi_pkg::*;

  // =====================================================================
  // direct page window
  // window offset is the low byte of the request; the sum wraps inside bank 0
  wire [15:0] dp_addr  = d.dp_base + {8'h00, d.addr_in[7:0]};
  wire [23:0] eff      = d.dp_mode ? {`EBI_BANK0, dp_addr} : d.addr_in;

  // =====================================================================
  // range decode
  wire        in_bank0 = (eff[23:16] == `EBI_BANK0);
  wire        hit_reg  = in_bank0 && (eff[15:0] <= `EBI_REG_LAST);
  wire        hit_ram  = in_bank0 && (eff[15:0] >= `EBI_RAM_FIRST)
                         && (eff[15:0] <= `EBI_RAM_LAST);

  assign d.eff_addr = eff;
  // everything else goes out on the pins
  assign d.tgt = hit_reg ? TGT_REG : (hit_ram ? TGT_RAM : TGT_EXT);
endmodule

/* File: hw/ebi_wait.sv */
// wait state counter and ready gate for one external data phase
`include "ebi_defs.svh"
module ebi_wait #(
  parameter int CNT_W    = 2,
  parameter int WAIT_CYC = `EBI_WAIT_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic load_i,
  input  wire logic wait_en_i,
  input  wire logic ready_n_i,
  output logic      done_o
);
  generate
    if (WAIT_CYC < 1 || WAIT_CYC + 1 >= (1 << CNT_W)) begin : g_bad
      $error("wait count does not fit the counter");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_r;

  // =====================================================================
  // count loads in the address phase, runs down in the data phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      // one extra count: the registered pins still show the address for a cycle
      cnt_r <= wait_en_i ? CNT_W'(WAIT_CYC + 1) : CNT_W'(1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // ready low stretches the phase beyond the inserted waits
  assign done_o = (cnt_r == '0) && ready_n_i;
endmodule

/* File: bench/ebi_mem_model.sv */
// external memory partner for the multiplexed bus
module ebi_mem_model (
  input  wire logic       clk_i,
  input  wire logic       byte_mode_i,
  input  wire logic [3:0] stall_i,
  input  wire logic [7:0] addr_lo_i,
  input  wire logic [7:0] mid_i,
  input  wire logic [7:0] hi_i,
  input  wire logic       rw_i,
  input  wire logic       ulsn_i,
  input  wire logic       ale_i,
  input  wire logic       strobe_n_i,
  output logic [7:0]      mid_o,
  output logic [7:0]      hi_o,
  output logic            ready_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [logic [23:0]];
  logic [23:0] a_r = 24'h0;
  logic [3:0]  cnt_r = 4'h0;
  logic [7:0]  mid_l = 8'h0;
  logic [7:0]  hi_l = 8'h0;
  wire         rd = !strobe_n_i && rw_i;
  // unwritten bytes read as a pattern made from their address: low byte xor bank byte
  function automatic logic [7:0] rdb(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[23:16];
  endfunction
  // released lanes never repeat the last value
  assign hi_o = rd ? rdb(byte_mode_i ? a_r : {a_r[23:1], 1'b0}) : ~hi_l;
  assign mid_o = rd && !byte_mode_i ? rdb({a_r[23:1], 1'b1}) : ~mid_l;
  assign ready_n_o = cnt_r == 4'h0;
  always @(posedge clk_i) begin
    hi_l <= hi_o;
    mid_l <= mid_o;
    if (ale_i) begin
      a_r <= {hi_i, mid_i, addr_lo_i};
      cnt_r <= stall_i;
    end else if (!strobe_n_i && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
    if (!strobe_n_i && !rw_i && (byte_mode_i || !a_r[0])) begin
      mem[byte_mode_i ? a_r : {a_r[23:1], 1'b0}] = hi_i;
    end
    if (!strobe_n_i && !rw_i && !byte_mode_i && !ulsn_i) begin
      mem[{a_r[23:1], 1'b1}] = mid_i;
    end
  end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the external bus interface
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
  // ==========
  // nets
  logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, we = 1'b0, word = 1'b0, dp = 1'b0;
  logic        wt = 1'b0, bm = 1'b0, hold_n = 1'b1, gwe = 1'b0;
  logic [23:0] addr = 24'h0, cur_a, lat_a;
  logic [15:0] wdata = 16'h0, base = 16'h0, rdata, iwd, int_rd, cur_v;
  logic [4:0]  gdir = 5'h0, goe;
  logic [3:0]  stall = 4'h0;
  logic [11:0] iaddr;
  logic [7:0]  alo, mo, mi, ho, hi;
  logic [1:0]  sel;
  logic        rdy, ack, rsel, msel, iwe, moe, hoe, coe, rw, ulsn, ale, stb_n, gack_n;
  logic        sclk, rdy_n, cur_w, cur_wd;
  int          failures = 0, checked = 0, stb_cnt = 0, beat = 0;
  logic [7:0]  shadow [logic [23:0]];
  logic [23:0] dir_a [8] = '{24'h012340, 24'h012345, 24'h00fffe, 24'h000880,
                             24'hff0000, 24'h7f00fd, 24'h00fffe, 24'h000880};
  wire  [7:0]  mbus = moe ? mo : mi;
  wire  [7:0]  hbus = hoe ? ho : hi;
  assign int_rd = {4'h0, iaddr} ^ 16'ha5c3;
  always #20 clk = ~clk;
  ebi_top #(.GPIO_W(5)) uut (
    .clk_i(clk), .rst_n_i(rst_n), .core_req_i(req), .core_we_i(we), .core_word_i(word),
    .core_dp_mode_i(dp), .core_addr_i(addr), .core_wdata_i(wdata),
    .direct_window_base_i(base), .wait_bit_i(wt), .core_ready_o(rdy), .core_ack_o(ack),
    .core_rdata_o(rdata), .int_reg_sel_o(rsel), .int_ram_sel_o(msel), .int_we_o(iwe),
    .int_addr_o(iaddr), .int_wdata_o(iwd), .int_rdata_i(int_rd), .byte_mode_i(bm),
    .hold_n_i(hold_n), .ready_n_i(rdy_n), .addr_lo_o(alo), .mid_o(mo), .mid_oe_o(moe),
    .mid_i(mbus), .hi_o(ho), .hi_oe_o(hoe), .hi_i(hbus), .ctl_oe_o(coe), .rw_o(rw),
    .upper_lane_select_n_o(ulsn), .ale_o(ale), .strobe_n_o(stb_n),
    .bus_grant_ack_n_o(gack_n), .sysclk_o(sclk), .gpio_dir_we_i(gwe),
    .gpio_dir_i(gdir), .gpio_oe_o(goe));
  ebi_mem_model mem (
    .clk_i(clk), .byte_mode_i(bm), .stall_i(stall), .addr_lo_i(alo), .mid_i(mbus),
    .hi_i(hbus), .rw_i(rw), .ulsn_i(ulsn), .ale_i(ale), .strobe_n_i(stb_n), .mid_o(mi),
    .hi_o(hi), .ready_n_o(rdy_n));
  function automatic logic [7:0] eb(input logic [23:0] a);
    return shadow.exists(a) ? shadow[a] : a[7:0] ^ a[23:16];
  endfunction
  // ==========
  // pin monitor
  always @(posedge clk) begin
    if (!stb_n) stb_cnt++;
    if (rsel === 1'b1 || msel === 1'b1) begin
      sel = {rsel, msel};
      `CHK({iwe, iwd}, {cur_w, cur_v})
    end
    if (!stb_n && bm) `CHK(mo, lat_a[15:8])
    if (ale === 1'b1) begin
      lat_a = cur_a + 24'(beat);
      `CHK({ho, mo, alo}, lat_a)
      `CHK(rw, !cur_w)
      `CHK(ulsn, !(lat_a[0] || (cur_wd && !bm && !cur_a[0])))
      beat++;
    end
  end
  // ==========
  // access tasks
  task automatic acc(input logic w, wd, d, input logic [23:0] a, input logic [15:0] v,
                     output logic [15:0] r);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    word <= wd;
    dp <= d;
    addr <= a;
    wdata <= v;
    do @(posedge clk); while (!(rdy === 1'b1 && hold_n === 1'b1) && n++ < 400);
    req <= 1'b0;
    cur_a = d ? {8'h00, base + {8'h00, a[7:0]}} : a;
    cur_w = w;
    cur_wd = wd;
    cur_v = v;
    beat = 0;
    stb_cnt = 0;
    sel = 2'b00;
    do @(posedge clk); while (ack !== 1'b1 && n++ < 400);
    `CHK(ack, 1'b1)
    r = rdata;
  endtask
  task automatic xt(input logic w, wd, input logic [23:0] a);
    logic [15:0] v, r;
    v = 16'($urandom);
    acc(w, wd, 1'b0, a, v, r);
    `CHK(stb_cnt, ((wd && (bm || a[0])) ? 2 : 1) * (1 + wt + stall))
    if (w) begin
      shadow[a] = v[7:0];
      if (wd) shadow[a + 24'h1] = v[15:8];
    end else `CHK(r, wd ? {eb(a + 24'h1), eb(a)} : {8'h00, eb(a)})
  endtask
  task automatic it(input logic d, input logic [23:0] a, input logic [11:0] ea, input logic g);
    logic [15:0] r;
    acc(1'b0, 1'b1, d, a, 16'h0, r);
    `CHK(sel, {g, !g})
    `CHK(r, {4'h0, ea} ^ 16'ha5c3)
    `CHK(stb_cnt, 0)
  endtask
  task automatic close_out;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    logic s;
    logic [15:0] r;
    void'($urandom(44825));
    repeat (2) @(posedge clk);
    `CHK({stb_n, gack_n, rw, ulsn, goe}, {4'hf, 5'h00})
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s = sclk;
    @(posedge clk);
    `CHK(sclk, !s)
    gwe <= 1'b1;
    gdir <= 5'h15;
    @(posedge clk);
    gwe <= 1'b0;
    @(posedge clk);
    `CHK(goe, 5'h15)
    foreach (dir_a[i]) begin
      bm <= i[2];
      xt(1'b1, 1'b1, dir_a[i]);
      xt(1'b0, 1'b1, dir_a[i]);
      xt(1'b0, 1'b0, dir_a[i] + 24'h1);
    end
    for (int i = 0; i < 60; i++) begin
      s = 1'($urandom);
      wt <= s;
      bm <= 1'($urandom);
      stall <= s ? 4'h0 : 4'($urandom_range(0, 3));
      xt(1'($urandom), 1'($urandom), {8'h01 + 8'h7f * 8'($urandom_range(0, 2)), 12'h0a5,
         4'($urandom)});
    end
    wt <= 1'b0;
    stall <= 4'h0;
    it(1'b0, 24'h000080, 12'h080, 1'b0);
    it(1'b0, 24'h00087e, 12'h87e, 1'b0);
    it(1'b0, 24'h00007e, 12'h07e, 1'b1);
    acc(1'b1, 1'b1, 1'b0, 24'h000100, 16'h5a3c, r);
    `CHK(sel, 2'b01)
    base <= 16'hffc0;
    it(1'b1, 24'h000050, 12'h010, 1'b1);
    base <= 16'h3f80;
    xt(1'b1, 1'b0, 24'h00407f);
    acc(1'b0, 1'b0, 1'b1, 24'h0000ff, 16'h0, r);
    `CHK(r, {8'h00, eb(24'h00407f)})
    hold_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK({gack_n, coe, moe, hoe}, 4'h0)
    fork
      xt(1'b0, 1'b1, 24'h012340);
      begin
        repeat (6) @(posedge clk);
        `CHK({gack_n, ale, stb_n}, 3'b001)
        hold_n <= 1'b1;
      end
    join
    `CHK(gack_n, 1'b1)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({gack_n, goe}, {1'b1, 5'h00})
    rst_n <= 1'b1;
    close_out();
  end
  initial begin
    #400us;
    failures++;
    close_out();
  end
endmodule
